//--- abs_position_serial_readout.sv
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module abs_position_serial_readout #(
    parameter int SERVO_ON_CYC  = abs_readout_pkg::SERVO_ON_CYC,
    parameter int FSTOP_CYC     = abs_readout_pkg::FSTOP_CYC,
    parameter int READY_CYC     = abs_readout_pkg::READY_CYC
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [7:0]             i_paddr,
    input  wire logic [31:0]            i_pwdata,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    input  wire logic                   i_req_valid,
    input  wire abs_readout_pkg::req_t  i_req,
    output abs_readout_pkg::resp_t      o_resp,
    output logic                        o_resp_valid,
    input  wire logic [31:0]            i_cur_pos,
    output logic      [31:0]            o_pos_cmd,
    output logic                        o_pos_load,
    output logic                        o_base_on,
    output logic                        o_ready,
    output logic                        o_irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        abs_readout_pkg::pwr_state_t st;
        logic [31:0]                 cnt;
        logic                        from_fstop;
        logic                        fstop_prev;
        logic [2:0]                  ctrl;
        logic [3:0]                  station;
        logic [2:0]                  irq_st;
        logic [2:0]                  irq_msk;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        abs_readout_pkg::resp_t      resp;
        logic                        resp_valid;
        logic [31:0]                 pos_cmd;
        logic                        pos_load;
        logic                        base_on;
        logic                        ready;
        logic                        irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
        is_addr = (a == ofs);
    endfunction

    logic       run;
    logic       fstop;
    logic       fault;
    logic       enabled;
    logic       acc;
    logic [2:0] ev;

    assign run     = s_q.ctrl[abs_readout_pkg::CTRL_RUN];
    assign fstop   = s_q.ctrl[abs_readout_pkg::CTRL_FSTOP];
    assign fault   = s_q.ctrl[abs_readout_pkg::CTRL_FAULT];
    assign enabled = run && !fstop && !fault;
    assign acc     = i_psel && i_penable && !s_q.pready;

    always_comb
    begin
        s_d            = s_q;
        ev             = 3'h0;
        s_d.pready     = 1'b0;
        s_d.pslverr    = 1'b0;
        s_d.resp_valid = 1'b0;
        s_d.pos_load   = 1'b0;
        s_d.fstop_prev = fstop;
        // ****************************************
        // Power sequence
        // ****************************************
        case (s_q.st)
            abs_readout_pkg::ST_OFF:
            begin
                s_d.cnt = 32'h0;
                if (enabled)
                begin
                    s_d.st         = abs_readout_pkg::ST_WAIT;
                    s_d.from_fstop = s_q.fstop_prev;
                end
            end
            abs_readout_pkg::ST_WAIT:
            begin
                s_d.cnt = s_q.cnt + 32'h1;
                // Release path uses the short end of the 200-450 ms window
                if (s_q.from_fstop ? (s_q.cnt == 32'(FSTOP_CYC - 1))
                                   : (s_q.cnt == 32'(SERVO_ON_CYC - 1))) // RULE7 RULE13
                begin
                    s_d.st      = abs_readout_pkg::ST_BASE;
                    s_d.cnt     = 32'h0;
                    s_d.base_on = 1'b1;
                end
            end
            abs_readout_pkg::ST_BASE:
            begin
                s_d.cnt = s_q.cnt + 32'h1;
                if (!s_q.from_fstop || s_q.cnt == 32'(READY_CYC - 1)) // RULE8 RULE13
                begin
                    s_d.st    = abs_readout_pkg::ST_READY;
                    s_d.ready = 1'b1;
                    ev[abs_readout_pkg::IRQ_READY] = 1'b1;
                end
            end
            abs_readout_pkg::ST_READY:
            begin
                s_d.cnt = 32'h0;
            end
            default:
            begin
                s_d.st = abs_readout_pkg::ST_OFF;
            end
        endcase
        if (!enabled) // RULE15
        begin
            s_d.st      = abs_readout_pkg::ST_OFF;
            s_d.base_on = 1'b0;
            s_d.ready   = 1'b0;
            s_d.cnt     = 32'h0;
        end
        // ****************************************
        // Serial command
        // ****************************************
        if (i_req_valid && i_req.station == {4'h0, s_q.station})
        begin
            s_d.resp_valid = 1'b1;
            s_d.resp.data  = 32'h0;
            if (i_req.link_err) // RULE10
            begin
                s_d.resp.err_code = abs_readout_pkg::ERR_LINK;
                ev[abs_readout_pkg::IRQ_ERR] = 1'b1;
            end
            else if (i_req.cmd != abs_readout_pkg::CMD_READ
                     || i_req.data_no != abs_readout_pkg::DATA_NO_ABSPOS) // RULE10
            begin
                s_d.resp.err_code = abs_readout_pkg::ERR_BAD_CMD;
                ev[abs_readout_pkg::IRQ_ERR] = 1'b1;
            end
            else
            begin
                s_d.resp.err_code = abs_readout_pkg::ERR_NONE;
                s_d.resp.data     = i_cur_pos; // RULE2 RULE6
                s_d.pos_cmd       = i_cur_pos; // RULE6
                s_d.pos_load      = 1'b1;
                ev[abs_readout_pkg::IRQ_READ] = 1'b1;
            end
        end
        // ****************************************
        // APB slave
        // ****************************************
        if (acc)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0;
            if (i_pwrite)
            begin
                if (is_addr(i_paddr, abs_readout_pkg::OFS_CTRL))
                    s_d.ctrl = i_pwdata[2:0];
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_IRQ_ST))
                    s_d.irq_st = s_q.irq_st & ~i_pwdata[2:0];
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_IRQ_MSK))
                    s_d.irq_msk = i_pwdata[2:0];
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_STATION))
                    s_d.station = i_pwdata[3:0];
                else if (!is_addr(i_paddr, abs_readout_pkg::OFS_STATUS)
                         && !is_addr(i_paddr, abs_readout_pkg::OFS_POSCMD))
                    s_d.pslverr = 1'b1;
            end
            else
            begin
                if (is_addr(i_paddr, abs_readout_pkg::OFS_CTRL))
                    s_d.prdata = {29'h0, s_q.ctrl};
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_STATUS))
                    s_d.prdata = {26'h0, s_q.st, s_q.ready, s_q.base_on};
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_IRQ_ST))
                    s_d.prdata = {29'h0, s_q.irq_st};
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_IRQ_MSK))
                    s_d.prdata = {29'h0, s_q.irq_msk};
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_POSCMD))
                    s_d.prdata = s_q.pos_cmd;
                else if (is_addr(i_paddr, abs_readout_pkg::OFS_STATION))
                    s_d.prdata = {28'h0, s_q.station};
                else
                    s_d.pslverr = 1'b1;
            end
        end
        // Set wins over a simultaneous write-one clear
        s_d.irq_st = s_d.irq_st | ev;
        s_d.irq    = |(s_d.irq_st & s_d.irq_msk);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s_q         <= '0;
            s_q.st      <= abs_readout_pkg::ST_OFF;
            s_q.station <= abs_readout_pkg::STATION_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_prdata     = s_q.prdata;
    assign o_pready     = s_q.pready;
    assign o_pslverr    = s_q.pslverr;
    assign o_resp       = s_q.resp;
    assign o_resp_valid = s_q.resp_valid;
    assign o_pos_cmd    = s_q.pos_cmd;
    assign o_pos_load   = s_q.pos_load;
    assign o_base_on    = s_q.base_on;
    assign o_ready      = s_q.ready;
    assign o_irq        = s_q.irq;

    // ****************************************
    // Checks
    // ****************************************
    a_ready_needs_base: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
        o_ready |-> o_base_on) else $error("ready without power stage");
    a_ready_low_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE15
        !enabled |=> !o_ready && !o_base_on) else $error("ready while disabled");
    a_base_rise_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
        $rose(o_base_on) |-> $past(s_q.st) == abs_readout_pkg::ST_WAIT)
        else $error("stage on without delay");
    a_stage_not_early: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
        (s_q.st == abs_readout_pkg::ST_WAIT && !s_q.from_fstop
         && s_q.cnt < 32'(SERVO_ON_CYC - 1)) |=> !o_base_on || !enabled)
        else $error("stage on too early");
    a_fstop_ready_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE13
        (s_q.st == abs_readout_pkg::ST_BASE && s_q.from_fstop
         && s_q.cnt < 32'(READY_CYC - 1)) |=> !o_ready)
        else $error("ready too soon after release");
    a_read_data: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
        (i_req_valid && i_req.station == {4'h0, s_q.station} && !i_req.link_err
         && i_req.cmd == abs_readout_pkg::CMD_READ
         && i_req.data_no == abs_readout_pkg::DATA_NO_ABSPOS)
        |=> o_resp_valid && o_resp.data == $past(i_cur_pos) && o_pos_cmd == o_resp.data)
        else $error("position reply wrong");
    a_load_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
        o_pos_load |-> o_resp_valid && o_resp.err_code == abs_readout_pkg::ERR_NONE)
        else $error("load without good reply");
    a_err_code: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
        (i_req_valid && i_req.station == {4'h0, s_q.station} && i_req.link_err)
        |=> o_resp_valid && o_resp.err_code == abs_readout_pkg::ERR_LINK && !o_pos_load)
        else $error("link error not reported");
endmodule // abs_position_serial_readout
`default_nettype wire

//--- abs_position_serial_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
module abs_position_serial_readout_tb;
    localparam int RUN_CYC = 20;
    localparam int FST_CYC = 30;
    localparam int RDY_CYC = 5;
    logic                   i_clk = 1'b0;
    logic                   i_rst_n = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            cur_pos = 32'h0;
    logic [31:0]            prdata, pos_cmd, q;
    logic                   pready, pslverr, req_valid, resp_valid, pos_load;
    logic                   base_on, ready, irq, e, got;
    logic [7:0]             stn;
    abs_readout_pkg::req_t  req;
    abs_readout_pkg::resp_t resp, r;
    int                     n, tries, mismatches = 0, n_checks = 0, cyc = 0;
    logic [31:0]            rst_tbl [6] = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};

    abs_position_serial_readout #(.SERVO_ON_CYC(RUN_CYC), .FSTOP_CYC(FST_CYC),
        .READY_CYC(RDY_CYC)) i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_req_valid(req_valid), .i_req(req),
        .o_resp(resp), .o_resp_valid(resp_valid), .i_cur_pos(cur_pos),
        .o_pos_cmd(pos_cmd), .o_pos_load(pos_load), .o_base_on(base_on),
        .o_ready(ready), .o_irq(irq));
    master_link_model i_master (.i_clk(i_clk), .i_resp_valid(resp_valid),
        .i_resp(resp), .o_req_valid(req_valid), .o_req(req));

    initial forever #4 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            mismatches++;
            results();
        end
    end

    // ****
    // Bus and check tasks
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1 && t < 20) @(posedge i_clk) t++;
        // A slave that never answers still ends as a failure
        if (t >= 20)
            mismatches++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_hi(input logic which);
        n = 0;
        do @(posedge i_clk) n++; while ((which ? ready : base_on) !== 1'b1 && n < 100);
    endtask

    // Window allows for the state machine's entry cycles
    task automatic power_up(input int lo, input int rdy);
        wait_hi(1'b0);
        check("base delay", 32'(n >= lo && n <= lo + 4), 32'h1);
        check("ready early", {31'h0, ready}, 32'h0);
        wait_hi(1'b1);
        check("ready delay", 32'(n >= rdy && n <= rdy + 1), 32'h1);
    endtask

    task automatic off_chk(input logic [31:0] ctrl);
        apb(1'b1, 8'h00, ctrl);
        repeat (2) @(posedge i_clk);
        check("stage off", {30'h0, base_on, ready}, 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] c, input int bad, input logic [7:0] x, input int k);
        cur_pos <= $urandom;
        i_master.read_pos(stn, c, bad, r, tries, got);
        check("reply", {31'h0, got}, 32'h1);
        check("err code", {24'h0, r.err_code}, {24'h0, x});
        check("tries", 32'(tries), 32'(k));
        if (x !== 8'h01)
            check("data", r.data, (x === 8'h00) ? cur_pos : 32'h0);
        if (x === 8'h00)
            check("pos cmd", pos_cmd, cur_pos);
        check("pos load", {31'h0, pos_load}, {31'h0, x === 8'h00});
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****
    // Test sequence
    // ****
    initial
    begin
        void'($urandom(32'h5C0FBC42));
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset value", q, rst_tbl[i]);
        end
        apb(1'b1, 8'h04, 32'hFFFFFFFF);
        apb(1'b0, 8'h04, 32'h0);
        check("status ro", q, 32'h4);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped", {31'h0, e}, 32'h1);
        $display("test registers done");
        stn = 8'($urandom_range(15, 1));
        apb(1'b1, 8'h14, {24'h0, stn});
        apb(1'b1, 8'h0C, 32'h7);
        apb(1'b1, 8'h00, 32'h1);
        power_up(RUN_CYC, 1);
        repeat (3) @(posedge i_clk);
        check("irq ready", {31'h0, irq}, 32'h1);
        $display("test power-on done");
        rd_chk(8'h02, 0, 8'h00, 1);
        apb(1'b0, 8'h10, 32'h0);
        check("poscmd reg", q, cur_pos);
        rd_chk(8'h05, 0, 8'h01, 4);
        rd_chk(8'h02, 2, 8'h00, 3);
        rd_chk(8'h02, 4, 8'h02, 4);
        i_master.read_pos(stn ^ 8'h01, 8'h02, 0, r, tries, got);
        check("other station", {31'h0, got}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check("irq status", q, 32'h7);
        apb(1'b1, 8'h08, 32'h7);
        apb(1'b1, 8'h0C, 32'h6);
        check("irq clear", {31'h0, irq}, 32'h0);
        $display("test reads done");
        off_chk(32'h5);
        apb(1'b1, 8'h00, 32'h1);
        power_up(RUN_CYC, 1);
        repeat (3) @(posedge i_clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check("sticky", q, 32'h1);
        rd_chk(8'h02, 0, 8'h00, 1);
        $display("test fault done");
        off_chk(32'h3);
        apb(1'b1, 8'h00, 32'h1);
        power_up(FST_CYC, RDY_CYC);
        rd_chk(8'h02, 0, 8'h00, 1);
        $display("test forced stop done");
        results();
    end
endmodule // abs_position_serial_readout_tb
`default_nettype wire

//--- abs_readout_pkg.sv
// Notes on behaviour
// [RULE1] Master reads position with command 0x02 and data number 0x91.
// [RULE2] Drive answers read with 32-bit position in pulses, hex encoded.
// [RULE3] Master addresses the read to the drive's own station number.
// [RULE4] Controller reads position every time servo-on is asserted.
// [RULE5] Controller applies a time-out to every position read.
// [RULE6] Drive returns position sampled at command, loads it as command value.
// [RULE7] Power stage enables 100 ms after servo-on request asserts.
// [RULE8] Ready output asserts only after power stage is enabled.
// [RULE9] Controller finishes position read before sending command pulses.
// [RULE10] On link error drive replies with matching error code, not data.
// [RULE11] Controller retries on error, then enters error handling.
// [RULE12] On fault controller drops servo-on, repeats power-on read sequence.
// [RULE13] Forced stop release: stage on after 200-450 ms, ready 5 ms later.
// [RULE14] Controller gets position before ready starts position commanding.
// [RULE15] Ready stays low whenever the power stage is disabled.
`default_nettype none
package abs_readout_pkg;
    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_READ       = 8'h02;
    localparam logic [7:0] DATA_NO_ABSPOS = 8'h91;
    localparam logic [7:0] ERR_NONE       = 8'h00;
    localparam logic [7:0] ERR_BAD_CMD    = 8'h01;
    localparam logic [7:0] ERR_LINK       = 8'h02;

    // ****************************************
    // APB map
    // ****************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h0C;
    localparam logic [7:0] OFS_POSCMD  = 8'h10;
    localparam logic [7:0] OFS_STATION = 8'h14;
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_FSTOP = 1;
    localparam int CTRL_FAULT = 2;
    localparam int IRQ_READY  = 0;
    localparam int IRQ_READ   = 1;
    localparam int IRQ_ERR    = 2;
    localparam logic [3:0] STATION_RST = 4'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ       = 125;
    localparam int SERVO_ON_MS   = 100;
    localparam int FSTOP_MIN_MS  = 200;
    localparam int READY_MS      = 5;
    localparam int CYC_PER_MS    = CLK_MHZ * 1000;
    localparam int SERVO_ON_CYC  = SERVO_ON_MS * CYC_PER_MS;
    localparam int FSTOP_CYC     = FSTOP_MIN_MS * CYC_PER_MS;
    localparam int READY_CYC     = READY_MS * CYC_PER_MS;

    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_BASE  = 4'b0100,
        ST_READY = 4'b1000
    } pwr_state_t;

    typedef struct packed {
        logic [7:0] station;
        logic [7:0] cmd;
        logic [7:0] data_no;
        logic       link_err;
    } req_t;

    typedef struct packed {
        logic [7:0]  err_code;
        logic [31:0] data;
    } resp_t;
endpackage
`default_nettype wire

//--- master_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module master_link_model (
    input  wire logic                   i_clk,
    input  wire logic                   i_resp_valid,
    input  wire abs_readout_pkg::resp_t i_resp,
    output logic                        o_req_valid,
    output abs_readout_pkg::req_t       o_req
);
    // ****
    // Read with time-out and retry
    // ****
    initial o_req_valid = 1'b0;
    initial o_req = '0;

    // Three tries; four means the error path was taken
    task automatic read_pos(input logic [7:0] stn, input logic [7:0] cmd, input int n_bad,
                            output abs_readout_pkg::resp_t r, output int tries,
                            output logic got);
        int t;
        got = 1'b0;
        for (tries = 1; tries <= 3; tries++)
        begin
            @(posedge i_clk);
            o_req_valid <= 1'b1;
            o_req <= '{stn, cmd, 8'h91, (tries <= n_bad)};
            @(posedge i_clk);
            o_req_valid <= 1'b0;
            o_req <= ~o_req;
            t = 0;
            // Silent drive must not hang us
            while (i_resp_valid !== 1'b1 && t < 8) @(posedge i_clk) t++;
            got = (t < 8);
            r = i_resp;
            if (!got || r.err_code === 8'h00)
                break;
        end
    endtask
endmodule // master_link_model
`default_nettype wire
